/* File: hw/ifsb_regs.svh */
// Register offsets, field positions and reset values of the flag bank.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef IFSB_REGS_SVH
`define IFSB_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define IFSB_OFS_FLAGS 4'h0
`define IFSB_OFS_MASK 4'h4
`define IFSB_OFS_CTRL 4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IFSB_BIT_SPI2_ERR 0
`define IFSB_BIT_SPI2_EVT 1
`define IFSB_BIT_CAN_RX 2
`define IFSB_BIT_CAN_EVT 3
`define IFSB_BIT_DMA3 4
`define IFSB_BIT_PMP 13
`define IFSB_BIT_DMA4 14
`define IFSB_IMPL_MASK 16'h601F
`define IFSB_CAN_MASK 16'h000C
`define IFSB_CTRL_CAN_BIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IFSB_RST_FLAGS 16'h0000
`define IFSB_RST_MASK 16'h0000
`define IFSB_RST_CAN 1'h1
`define IFSB_RST_RDATA 32'h00000000
`define IFSB_RST_IRQ 1'h0
`define IFSB_RST_ACK 1'h0

// ----------------------------------------------------------------
// Read padding above the 16-bit word and the 1-bit control field
// ----------------------------------------------------------------
`define IFSB_RD_PAD 16'h0000
`define IFSB_CTRL_PAD 31'h00000000

`endif

/* File: hw/ifsb_pkg.sv */
// Types shared by the flag bank files.
// Assumes nothing of its surroundings.
package ifsb_pkg;
  typedef logic [15:0] ifsb_word_t;
  typedef enum logic [1:0] {
    IFSB_IDLE = 2'h0,
    IFSB_ACK = 2'h1
  } ifsb_bus_t;
endpackage

/* File: hw/ifsb_wb_slave.sv */
// Classic Wishbone handshake: one-cycle ack per request, then a gap.
// Assumes the master holds its request until it samples ack.
`include "ifsb_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ifsb_wb_slave (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Bus request
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  // Accept strobe to the register file
  output logic accept,
  output logic wb_ack_o
);
  ifsb_pkg::ifsb_bus_t state_q;
  ifsb_pkg::ifsb_bus_t state_d;
  logic ack_q;
  logic ack_d;

  // Ack state: idle, then one ack cycle, so ack drops the cycle after it
  always_comb begin
    state_d = ifsb_pkg::IFSB_IDLE;
    case (state_q)
      ifsb_pkg::IFSB_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          state_d = ifsb_pkg::IFSB_ACK;
        end
      end
      default: begin
        state_d = ifsb_pkg::IFSB_IDLE;
      end
    endcase
    // Ack flop of its own so the pin comes straight from a register
    ack_d = (state_d == ifsb_pkg::IFSB_ACK);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= ifsb_pkg::IFSB_IDLE;
      ack_q <= `IFSB_RST_ACK;
    end else begin
      state_q <= state_d;
      ack_q <= ack_d;
    end
  end

  // Take effect at the edge where ack is sampled
  assign accept = (state_q == ifsb_pkg::IFSB_ACK) && wb_cyc_i && wb_stb_i;
  assign wb_ack_o = ack_q;
endmodule
`default_nettype wire

/* File: hw/ifsb_flag_bank.sv */
// Second interrupt flag status bank with Wishbone access and one irq line.
// Assumes source request pulses are synchronous to clk_sys.
`include "ifsb_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ifsb_flag_bank (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Source request pulses
  input wire logic dmaCh4DoneReq,
  input wire logic parallelPortReq,
  input wire logic dmaCh3DoneReq,
  input wire logic canEventReq,
  input wire logic canRxReadyReq,
  input wire logic spiCh2EventReq,
  input wire logic spiCh2ErrorReq,
  // Interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ifsb_pkg::ifsb_word_t flags_q;
  ifsb_pkg::ifsb_word_t flags_d;
  ifsb_pkg::ifsb_word_t mask_q;
  ifsb_pkg::ifsb_word_t mask_d;
  logic canPresent_q;
  logic canPresent_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic accept;
  logic ackRaw;
  ifsb_pkg::ifsb_word_t events;
  ifsb_pkg::ifsb_word_t wmask;
  logic wrFlags;
  logic wrMask;
  logic wrCtrl;
  logic rdTake;

  // Byte lanes 0 and 1 carry the 16-bit word
  function automatic ifsb_pkg::ifsb_word_t lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  ifsb_wb_slave u_slave (
    .clk_sys(clk_sys),
    .srst(srst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .accept(accept),
    .wb_ack_o(ackRaw)
  );
  assign wb_ack_o = ackRaw; // Flop output inside slave

  // Event vector in bit order
  always_comb begin
    events = `IFSB_RST_FLAGS;
    events[`IFSB_BIT_DMA4] = dmaCh4DoneReq;
    events[`IFSB_BIT_PMP] = parallelPortReq;
    events[`IFSB_BIT_DMA3] = dmaCh3DoneReq;
    events[`IFSB_BIT_CAN_EVT] = canEventReq && canPresent_q;
    events[`IFSB_BIT_CAN_RX] = canRxReadyReq && canPresent_q;
    events[`IFSB_BIT_SPI2_EVT] = spiCh2EventReq;
    events[`IFSB_BIT_SPI2_ERR] = spiCh2ErrorReq;
  end

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  // Strobes fire only in the ack cycle, so each write lands exactly once
  always_comb begin
    wrFlags = 1'b0;
    wrMask = 1'b0;
    wrCtrl = 1'b0;
    if (accept && wb_we_i) begin
      if (wb_adr_i == `IFSB_OFS_FLAGS) begin
        wrFlags = 1'b1;
      end else if (wb_adr_i == `IFSB_OFS_MASK) begin
        wrMask = 1'b1;
      end else if (wb_adr_i == `IFSB_OFS_CTRL) begin
        wrCtrl = 1'b1;
      end
    end
  end
  assign wmask = lane_mask(wb_sel_i);

  // ----------------------------------------------------------------
  // CAN presence control
  // ----------------------------------------------------------------
  // Presence bit rides on lane 0 only
  always_comb begin
    canPresent_d = canPresent_q;
    if (wrCtrl && wb_sel_i[0]) begin
      canPresent_d = wb_dat_i[`IFSB_CTRL_CAN_BIT];
    end
  end

  // Presence register; comes up present
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      canPresent_q <= `IFSB_RST_CAN;
    end else begin
      canPresent_q <= canPresent_d;
    end
  end

  // ----------------------------------------------------------------
  // Flag word
  // ----------------------------------------------------------------
  // Software write first, then events on top: a set beats a same-cycle clear
  always_comb begin
    flags_d = flags_q;
    if (wrFlags) begin
      // Plain writable flags: software may set or clear
      flags_d = (flags_q & ~wmask) | (wb_dat_i[15:0] & wmask);
    end
    flags_d = flags_d | events;
    if (!canPresent_d) begin
      // Dropping presence clears the CAN pair at once
      flags_d = flags_d & ~`IFSB_CAN_MASK;
    end
    flags_d = flags_d & `IFSB_IMPL_MASK;
  end

  // Flag register; sticky, since only a write can lower a bit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flags_q <= `IFSB_RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt mask
  // ----------------------------------------------------------------
  // Same layout as the flag word; unused bits stay zero
  always_comb begin
    mask_d = mask_q;
    if (wrMask) begin
      mask_d = (mask_q & ~wmask) | (wb_dat_i[15:0] & wmask);
    end
    mask_d = mask_d & `IFSB_IMPL_MASK;
  end

  // Mask register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mask_q <= `IFSB_RST_MASK;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt line
  // ----------------------------------------------------------------
  // Built from next values so irq rises at the same edge as its flag
  always_comb begin
    irq_d = |(flags_d & mask_d);
  end

  // Registered so the pin never glitches
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_q <= `IFSB_RST_IRQ;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Captured the cycle before ack, so it stands for the whole ack cycle
  always_comb begin
    rdTake = wb_cyc_i && wb_stb_i && !wb_we_i && !ackRaw;
    rdata_d = rdata_q;
    if (rdTake) begin
      // Unmapped addresses read zero
      if (wb_adr_i == `IFSB_OFS_FLAGS) begin
        rdata_d = {`IFSB_RD_PAD, flags_q};
      end else if (wb_adr_i == `IFSB_OFS_MASK) begin
        rdata_d = {`IFSB_RD_PAD, mask_q};
      end else if (wb_adr_i == `IFSB_OFS_CTRL) begin
        rdata_d = {`IFSB_CTRL_PAD, canPresent_q};
      end else begin
        rdata_d = `IFSB_RST_RDATA;
      end
    end
  end

  // Read data register; holds until the next read
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_q <= `IFSB_RST_RDATA;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, straight from flops
  // ----------------------------------------------------------------
  assign wb_dat_o = rdata_q;
  assign irq = irq_q;
endmodule
`default_nettype wire

/* File: testbench/ifsb_flag_bank_asserts.sv */
// Checker for the flag bank, bound to its top module.
// Assumes a master that holds address and data until it samples ack.
`timescale 1ns/1ps
`default_nettype none
module ifsb_flag_bank_asserts (
  // Clock, reset and bus
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Sources and interrupt
  input wire logic parallelPortReq,
  input wire logic canRxReadyReq,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic canOff_q;
  // Inverted shadow of the CAN present bit (high while absent), so reads can be judged
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      canOff_q <= 1'b0;
    end else if (wb_ack_o && wb_we_i && wb_adr_i == 4'h8 && wb_sel_i[0]) begin
      canOff_q <= !wb_dat_i[0];
    end
  end
  // Request raised while the slave is idle
  sequence busReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Flag read taken, answer still to come
  sequence rdFlags;
    wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == 4'h0 && !wb_ack_o;
  endsequence
  a_port_flag: assert property (
    parallelPortReq ##2 rdFlags |=> wb_dat_o[13]) else $error("port flag not seen");
  a_rx_flag: assert property (
    canRxReadyReq && !canOff_q ##2 rdFlags |=> wb_dat_o[2]) else $error("rx flag not seen");
  a_ack_once: assert property (
    busReq |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");
  a_reset_quiet: assert property (
    $fell(srst) |-> !irq && !wb_ack_o && wb_dat_o == 32'h0) else $error("not quiet");
  a_unused_zero: assert property (
    wb_ack_o |-> (wb_dat_o & 32'hFFFF9FE0) == 32'h0) else $error("unused bit set");
  a_can_off: assert property (
    canOff_q && wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> wb_dat_o[3:2] == 2'h0)
    else $error("CAN flag set while absent");
endmodule
bind ifsb_flag_bank ifsb_flag_bank_asserts chk_u (.*);
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the flag bank.
// Assumes the bound checker and a one-cycle registered ack.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, irq;
  logic [6:0] req = 7'h0;
  int error_cnt = 0, n_checks = 0;
  int bitOf[7] = '{0, 1, 2, 3, 4, 13, 14};
  wire logic dmaCh4DoneReq, parallelPortReq, dmaCh3DoneReq, canEventReq;
  wire logic canRxReadyReq, spiCh2EventReq, spiCh2ErrorReq;
  assign {dmaCh4DoneReq, parallelPortReq, dmaCh3DoneReq, canEventReq, canRxReadyReq,
    spiCh2EventReq, spiCh2ErrorReq} = req;
  ifsb_flag_bank dut_u (
    .clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dmaCh4DoneReq(dmaCh4DoneReq),
    .parallelPortReq(parallelPortReq), .dmaCh3DoneReq(dmaCh3DoneReq),
    .canEventReq(canEventReq), .canRxReadyReq(canRxReadyReq),
    .spiCh2EventReq(spiCh2EventReq), .spiCh2ErrorReq(spiCh2ErrorReq), .irq(irq)
  );
  always #10 clk_sys = ~clk_sys;
  task chk(input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; waits for ack, gap after
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task pulse(input logic [6:0] r);
    req <= r;
    @(posedge clk_sys);
    req <= 7'h0;
    @(posedge clk_sys);
  endtask
  task t_reset;
    wb(1'b0, 4'h0, 32'h0); chk(32'h0, rd);
    wb(1'b0, 4'h8, 32'h0); chk(32'h1, rd);
    $display("reset test done");
  endtask
  // Each source alone: set, sticky, irq, clear
  task t_sources;
    wb(1'b1, 4'h4, 32'h601F);
    for (int i = 0; i < 7; i++) begin
      pulse(7'h1 << i);
      wb(1'b0, 4'h0, 32'h0); chk(32'h1 << bitOf[i], rd);
      wb(1'b0, 4'h0, 32'h0); chk(32'h1 << bitOf[i], rd);
      chk(32'h1, {31'h0, irq});
      wb(1'b1, 4'h0, 32'h0);
      wb(1'b0, 4'h0, 32'h0); chk(32'h0, rd);
      chk(32'h0, {31'h0, irq});
    end
    wb(1'b1, 4'h4, 32'h0);
    pulse(7'h40);
    chk(32'h0, {31'h0, irq});
    $display("source test done");
  endtask
  task t_layout;
    wb(1'b1, 4'h0, 32'hFFFFFFFF);
    wb(1'b0, 4'h0, 32'h0); chk(32'h601F, rd);
    wb(1'b0, 4'hC, 32'h0); chk(32'h0, rd);
    wb(1'b1, 4'h8, 32'h0);
    wb(1'b0, 4'h0, 32'h0); chk(32'h6013, rd);
    pulse(7'h08);
    wb(1'b0, 4'h0, 32'h0); chk(32'h6013, rd);
    $display("layout test done");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset;
    t_sources;
    t_layout;
    give_verdict;
  end
  // Watchdog well past the roughly 140 cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    give_verdict;
  end
endmodule
`default_nettype wire
